/* verilog/sfi_cfg.svh */
// Constants for the serial flash ID, hold and protect front end.
// Assumes a 200 MHz system clock on both ends.
`ifndef SFI_CFG_SVH
`define SFI_CFG_SVH

// ---------------------------------------------------------------
// Opcodes
// ---------------------------------------------------------------
`define SFI_OP_JEDEC_ID  8'h9f
`define SFI_OP_SHORT_ID  8'hab
`define SFI_OP_WR_EN     8'h06
`define SFI_OP_WR_DIS    8'h04
`define SFI_OP_PWR_DOWN  8'hb9
`define SFI_OP_SS_ERASE  8'h20
`define SFI_OP_SS_ERASE2 8'hd7
`define SFI_OP_SEC_ERASE 8'hd8
`define SFI_OP_CHIP_ER   8'h60
`define SFI_OP_CHIP_ER2  8'hc7
`define SFI_OP_PAGE_PROG 8'h02
`define SFI_OP_STAT_WR   8'h01

// ---------------------------------------------------------------
// Frame lengths in bus cycles, and fixed ID bytes
// ---------------------------------------------------------------
`define SFI_LEN_OPCODE   12'h001
`define SFI_LEN_ADDR_CMD 12'h004
`define SFI_LEN_STAT_WR  12'h002
`define SFI_LEN_PROG_MIN 12'h005
`define SFI_ID_RESERVED  8'h00

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SFI_CLK_MHZ       200
`define SFI_PU_WAIT_US    500
`define SFI_PU_WAIT_CYC   (`SFI_PU_WAIT_US * `SFI_CLK_MHZ)
`define SFI_SCK_HALF_CYC  8

`endif

/* verilog/sfi_pkg.sv */
// Types shared by both ends of the serial flash link.
// Assumes sfi_cfg.svh for numeric constants.
package sfi_pkg;

    // Device frame decoding
    typedef enum logic [1:0] {
        SFI_DM_CMD,
        SFI_DM_JID,
        SFI_DM_SID
    } sfi_dmode_t;

    // Host sequencer
    typedef enum logic [1:0] {
        SFI_HS_PWRUP,
        SFI_HS_IDLE,
        SFI_HS_RUN,
        SFI_HS_END
    } sfi_hstate_t;

endpackage : sfi_pkg

/* verilog/sfi_link_if.sv */
// Serial link between the host end and the flash end.
// Assumes the bench resolves the output line from so_oe.
`timescale 1ns/1ps
interface sfi_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    logic hold_n;

    modport host (output cs_n, output sck, output si, output hold_n, input so, input so_oe);
    modport dev  (input cs_n, input sck, input si, input hold_n, output so, output so_oe);
endinterface : sfi_link_if

/* verilog/sfi_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous pin inputs; reset value is a parameter.
`timescale 1ns/1ps
module sfi_sync #(
    parameter int         W   = 4,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // Stage one feeds stage two only; filter looks at two and three
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s1  <= RST;
            s2  <= RST;
            s3  <= RST;
            q_o <= RST;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    q_o[i] <= s3[i];
                end
            end
        end
    end
endmodule : sfi_sync

/* verilog/sfi_device.sv */
// Flash end of the link: ID reads, hold, power state, write guards.
// Assumes link pins are asynchronous to clk_i and the array core
// reports busy and write completion on clk_i.
`timescale 1ns/1ps
`include "sfi_cfg.svh"

// Notes on behaviour
// - No ID read while write busy
// - 9Fh returns maker, type, capacity, reserved
// - Four ID bytes repeat while clocking
// - ABh plus 24 dummy bits gives ID
// - Short ID byte repeats while clocking
// - Output starts on falling edge; CS ends
// - Hold on fall with SCK low, exit rise
// - Host changes hold only while SCK low
// - Hold needs CS low; CS rise resets
// - Held: output off, SI and SCK ignored
// - Host waits 500 us after power-up
// - Start in standby, not power-down
// - Write needs CS rise on byte boundary
// - Program needs whole data bytes
// - Status write with two data bytes ignored
// - Write completion clears write enable
// - ABh opcode byte exits power-down
module sfi_device import sfi_pkg::*; #(
    parameter logic [7:0] MAKER_ID = 8'ha5, // Arbitrary value
    parameter logic [7:0] TYPE_ID  = 8'h5a, // Arbitrary value
    parameter logic [7:0] CAP_ID   = 8'h3c, // Arbitrary value
    parameter logic [7:0] SHORT_ID = 8'hc3  // Arbitrary value
) (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    sfi_link_if.dev         link,
    input  wire logic       busy_i,
    input  wire logic       write_done_i,
    output logic            wen_o,
    output logic            pd_o,
    output logic            held_o,
    output logic            wr_start_o,
    output logic [7:0]      wr_op_o
);
    // ---------------------------------------------------------------
    // Pin sampling
    // ---------------------------------------------------------------
    logic [3:0]  pins;
    logic        cs_n;
    logic        sck;
    logic        si;
    logic        hold_n;
    logic        cs_d;
    logic        sck_d;
    logic        hold_d;

    sfi_sync #(.W(4), .RST(4'h9)) u_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .d_i     ({link.cs_n, link.sck, link.si, link.hold_n}),
        .q_o     (pins)
    );

    assign cs_n   = pins[3];
    assign sck    = pins[2];
    assign si     = pins[1];
    assign hold_n = pins[0];

    // Previous filtered levels for edge finding
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cs_d   <= 1'b1;
            sck_d  <= 1'b0;
            hold_d <= 1'b1;
        end else begin
            cs_d   <= cs_n;
            sck_d  <= sck;
            hold_d <= hold_n;
        end
    end

    logic        cs_rise;
    logic        sck_rise;
    logic        sck_fall;
    logic [11:0] nbytes;
    logic [2:0]  nbits;
    logic [7:0]  sh;
    logic [7:0]  op;
    logic [7:0]  cur_byte;
    logic        whole;
    logic        op_done;
    sfi_dmode_t  mode;

    assign cs_rise  = cs_n & ~cs_d;
    // Clock edges count only in a frame and out of hold
    assign sck_rise = sck & ~sck_d & ~cs_n & ~held_o;
    assign sck_fall = ~sck & sck_d & ~cs_n & ~held_o;
    assign whole    = (nbits == 3'h0);
    assign op_done  = sck_rise && nbytes == 12'h000 && nbits == 3'h7;
    assign cur_byte = {sh[6:0], si};

    // ---------------------------------------------------------------
    // Functions
    // ---------------------------------------------------------------
    // Length check for write-type opcodes, in whole bus cycles
    function automatic logic len_ok(input logic [7:0] o, input logic [11:0] n);
        case (o)
            `SFI_OP_SS_ERASE, `SFI_OP_SS_ERASE2, `SFI_OP_SEC_ERASE:
                len_ok = (n == `SFI_LEN_ADDR_CMD);
            `SFI_OP_CHIP_ER, `SFI_OP_CHIP_ER2:
                len_ok = (n == `SFI_LEN_OPCODE);
            `SFI_OP_PAGE_PROG:
                len_ok = (n >= `SFI_LEN_PROG_MIN);
            `SFI_OP_STAT_WR:
                len_ok = (n == `SFI_LEN_STAT_WR);
            default:
                len_ok = 1'b0;
        endcase
    endfunction : len_ok

    // ID byte for the repeating four-byte sequence
    function automatic logic [7:0] jid_byte(input logic [1:0] i);
        case (i)
            2'h0:    jid_byte = MAKER_ID;
            2'h1:    jid_byte = TYPE_ID;
            2'h2:    jid_byte = CAP_ID;
            default: jid_byte = `SFI_ID_RESERVED;
        endcase
    endfunction : jid_byte

    // ---------------------------------------------------------------
    // Hold state
    // ---------------------------------------------------------------
    // Hold only inside a frame; entered only with SCK low, exit on any hold rise whatever SCK is
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            held_o <= 1'b0;
        end else if (cs_n) begin
            held_o <= 1'b0;
        end else if (!hold_n && hold_d && !sck) begin
            held_o <= 1'b1;
        end else if (hold_n && !hold_d) begin
            held_o <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Shift in and count
    // ---------------------------------------------------------------
    // Byte count saturates so long program loads still pass the length check
    always_ff @(posedge clk_i) begin
        if (reset_i || cs_n) begin
            nbytes <= 12'h000;
            nbits  <= 3'h0;
            sh     <= 8'h00;
        end else if (sck_rise) begin
            sh    <= cur_byte;
            nbits <= nbits + 3'h1;
            if (nbits == 3'h7 && nbytes != 12'hfff) begin
                nbytes <= nbytes + 12'h001;
            end
        end
    end

    // Opcode capture and frame mode
    always_ff @(posedge clk_i) begin
        if (reset_i || cs_n) begin
            op   <= 8'h00;
            mode <= SFI_DM_CMD;
        end else if (op_done) begin
            op <= cur_byte;
            case (cur_byte)
                `SFI_OP_JEDEC_ID:
                    mode <= (busy_i || pd_o) ? SFI_DM_CMD : SFI_DM_JID;
                `SFI_OP_SHORT_ID:
                    mode <= busy_i ? SFI_DM_CMD : SFI_DM_SID;
                default:
                    mode <= SFI_DM_CMD;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // ID output
    // ---------------------------------------------------------------
    logic       out_act;
    logic [2:0] obit;
    logic [1:0] oidx;
    logic       first_fall;
    logic [7:0] obyte;

    // Start at the fall after the opcode, or after the dummy bits
    assign first_fall = (mode == SFI_DM_JID && nbytes == `SFI_LEN_OPCODE) ||
                        (mode == SFI_DM_SID && nbytes == `SFI_LEN_ADDR_CMD);
    assign obyte      = (mode == SFI_DM_JID) ? jid_byte(oidx) : SHORT_ID;

    // Bit driven on each falling edge, MSB first
    always_ff @(posedge clk_i) begin
        if (reset_i || cs_n) begin
            out_act <= 1'b0;
            obit    <= 3'h0;
            oidx    <= 2'h0;
            link.so <= 1'b0;
        end else if (sck_fall && (out_act || (first_fall && whole))) begin
            out_act <= 1'b1;
            link.so <= obyte[3'h7 - obit];
            obit    <= obit + 3'h1;
            if (obit == 3'h7 && mode == SFI_DM_JID) begin
                oidx <= oidx + 2'h1;
            end
        end
    end
    // Short ID byte index never moves, so it repeats as is

    // Driver enabled only while output is live and not held
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            link.so_oe <= 1'b0;
        end else begin
            link.so_oe <= ~cs_n & ~held_o & (out_act |
                          (sck_fall && first_fall && whole));
        end
    end

    // ---------------------------------------------------------------
    // Power state and write enable
    // ---------------------------------------------------------------
    // Standby after reset; power-down only on command
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pd_o <= 1'b0;
        end else if (op_done && cur_byte == `SFI_OP_SHORT_ID) begin
            pd_o <= 1'b0;
        end else if (cs_rise && whole && nbytes == `SFI_LEN_OPCODE &&
                     op == `SFI_OP_PWR_DOWN && !busy_i) begin
            pd_o <= 1'b1;
        end
    end

    logic cmd_ok;
    // Single-cycle commands honoured only on a clean boundary
    assign cmd_ok = cs_rise && whole && !busy_i && !pd_o &&
                    nbytes == `SFI_LEN_OPCODE;

    // Completion clear wins; a failed write leaves the latch alone
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wen_o <= 1'b0;
        end else if (write_done_i) begin
            wen_o <= 1'b0;
        end else if (cmd_ok && op == `SFI_OP_WR_EN) begin
            wen_o <= 1'b1;
        end else if (cmd_ok && op == `SFI_OP_WR_DIS) begin
            wen_o <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Write launch
    // ---------------------------------------------------------------
    // Malformed frames are dropped silently, as the array expects
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wr_start_o <= 1'b0;
            wr_op_o    <= 8'h00;
        end else begin
            wr_start_o <= cs_rise && whole && wen_o && !busy_i && !pd_o &&
                          len_ok(op, nbytes);
            if (cs_rise) begin
                wr_op_o <= op;
            end
        end
    end

endmodule : sfi_device

/* verilog/sfi_host.sv */
// Host end of the link: power-up wait, framed transfers, hold.
// Assumes the user holds tx_data_i steady until tx_take_o.
`timescale 1ns/1ps
`include "sfi_cfg.svh"
module sfi_host import sfi_pkg::*; #(
    parameter int PU_CYC = `SFI_PU_WAIT_CYC,
    parameter int HALF   = `SFI_SCK_HALF_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    sfi_link_if.host        link,
    input  wire logic       start_i,
    input  wire logic [7:0] op_i,
    input  wire logic [8:0] tx_len_i,
    input  wire logic [8:0] rx_len_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       hold_req_i,
    output logic            ready_o,
    output logic            tx_take_o,
    output logic [7:0]      rx_data_o,
    output logic            rx_valid_o
);
    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    sfi_hstate_t state;
    logic [16:0] cnt;
    logic [2:0]  bitn;
    logic [9:0]  byten;
    logic [9:0]  total;
    logic [8:0]  txn;
    logic [7:0]  tsh;
    logic [7:0]  rsh;
    logic        tick;
    logic        pause;

    assign tick  = (cnt == 17'(HALF - 1));
    // Clock frozen while hold is asked or still low
    assign pause = hold_req_i | ~link.hold_n;

    // Frame flow; so is sampled on every SCK rise, whether or not the device drives it
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state      <= SFI_HS_PWRUP;
            cnt        <= 17'h00000;
            ready_o    <= 1'b0;
            link.cs_n  <= 1'b1;
            link.sck   <= 1'b0;
            link.si    <= 1'b0;
            bitn       <= 3'h0;
            byten      <= 10'h000;
            total      <= 10'h000;
            txn        <= 9'h000;
            tsh        <= 8'h00;
            rsh        <= 8'h00;
            tx_take_o  <= 1'b0;
            rx_data_o  <= 8'h00;
            rx_valid_o <= 1'b0;
        end else begin
            tx_take_o  <= 1'b0;
            rx_valid_o <= 1'b0;
            case (state)
                SFI_HS_PWRUP: begin
                    cnt <= cnt + 17'h00001;
                    if (cnt == 17'(PU_CYC - 1)) begin
                        cnt     <= 17'h00000;
                        ready_o <= 1'b1;
                        state   <= SFI_HS_IDLE;
                    end
                end
                SFI_HS_IDLE: begin
                    if (start_i) begin
                        ready_o   <= 1'b0;
                        link.cs_n <= 1'b0;
                        link.si   <= op_i[7];
                        tsh       <= {op_i[6:0], 1'b0};
                        txn       <= tx_len_i;
                        total     <= 10'h001 + 10'(tx_len_i) + 10'(rx_len_i);
                        bitn      <= 3'h0;
                        byten     <= 10'h000;
                        cnt       <= 17'h00000;
                        state     <= SFI_HS_RUN;
                    end
                end
                SFI_HS_RUN: begin
                    if (link.sck || !pause) begin
                        cnt <= tick ? 17'h00000 : cnt + 17'h00001;
                    end
                    if (tick && !link.sck && !pause) begin
                        link.sck <= 1'b1;
                        rsh      <= {rsh[6:0], link.so};
                    end else if (tick && link.sck) begin
                        link.sck <= 1'b0;
                        bitn     <= bitn + 3'h1;
                        link.si  <= tsh[7];
                        tsh      <= {tsh[6:0], 1'b0};
                        if (bitn == 3'h7) begin
                            byten <= byten + 10'h001;
                            if (byten > 10'(txn)) begin
                                rx_data_o  <= rsh;
                                rx_valid_o <= 1'b1;
                            end
                            if (byten + 10'h001 == total) begin
                                state <= SFI_HS_END;
                            end else if (byten < 10'(txn)) begin
                                link.si   <= tx_data_i[7];
                                tsh       <= {tx_data_i[6:0], 1'b0};
                                tx_take_o <= 1'b1;
                            end else begin
                                link.si <= 1'b0;
                            end
                        end
                    end
                end
                SFI_HS_END: begin
                    link.cs_n <= 1'b1;
                    cnt       <= cnt + 17'h00001;
                    if (tick) begin
                        cnt     <= 17'h00000;
                        ready_o <= 1'b1;
                        state   <= SFI_HS_IDLE;
                    end
                end
                default: state <= SFI_HS_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Hold pin
    // ---------------------------------------------------------------
    // Moves only while SCK is low and inside a frame
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            link.hold_n <= 1'b1;
        end else if (state == SFI_HS_RUN && !link.sck) begin
            link.hold_n <= ~hold_req_i;
        end else if (state != SFI_HS_RUN) begin
            link.hold_n <= 1'b1;
        end
    end

endmodule : sfi_host

/* tb/sfi_link_sva.sv */
// Link checker for the serial flash ID, hold and protect front end.
// Assumes plain link signals sampled on the host clock clk_i.
`timescale 1ns/1ps
module sfi_link_sva #(
    parameter int PU_CYC = 20
) (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic so,
    input  wire logic so_oe,
    input  wire logic hold_n
);
    // --------------------------
    // Power-up count
    // --------------------------
    int up_cnt;

    // Saturates so a long run never wraps it
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            up_cnt <= 0;
        end else if (up_cnt < PU_CYC) begin
            up_cnt <= up_cnt + 1;
        end
    end

    // --------------------------
    // Link properties
    // --------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_hold_sck_low: assert property (!$stable(hold_n) |-> !sck)
        else $error("hold moved while clock high");
    a_hold_sck_frozen: assert property (!hold_n |-> !sck)
        else $error("clock ran during hold");
    a_hold_out_off: assert property (!hold_n [*8] |-> !so_oe)
        else $error("output driven during hold");
    a_idle_out_off: assert property (cs_n [*8] |-> !so_oe)
        else $error("output driven while deselected");
    a_opcode_out_off: assert property ($fell(cs_n) |-> !so_oe [*8])
        else $error("output driven during opcode");
    a_out_start_fall: assert property ($rose(so_oe) |-> !sck && !cs_n && hold_n)
        else $error("output started off a falling edge");
    a_out_bit_fall: assert property (so_oe && $changed(so) |-> !sck)
        else $error("output bit changed with clock high");
    a_powerup_wait: assert property (!cs_n |-> up_cnt >= PU_CYC)
        else $error("frame before power-up wait");
endmodule : sfi_link_sva

/* tb/test_serial_flash_id_hold_protect.sv */
// Bench for both link ends plus a bit-level driver on a second device.
// Assumes sfi_cfg.svh on the include path and host clock of 200 MHz.
`timescale 1ns/1ps
`include "sfi_cfg.svh"
module test_serial_flash_id_hold_protect import sfi_pkg::*;;
    localparam int PU = 20;
    localparam logic [7:0] IDS [5] = '{8'h71, 8'h2e, 8'h48, `SFI_ID_RESERVED, 8'hd6}; // Arbitrary IDs
    localparam logic [7:0] WOPS [7] = '{`SFI_OP_SS_ERASE, `SFI_OP_SS_ERASE2, `SFI_OP_SEC_ERASE,
        `SFI_OP_CHIP_ER, `SFI_OP_CHIP_ER2, `SFI_OP_PAGE_PROG, `SFI_OP_STAT_WR};
    localparam int WLEN [7] = '{3, 3, 3, 0, 0, 4, 1};
    logic       clk_i = 0, reset_i = 1, start_i = 0, hold_req_i = 0, busy_i = 0;
    logic       write_done_i = 0, ign = 0, oe_seen = 0;
    logic [7:0] op_i = 0, tx_data_i = 8'h09, rnd = 8'h09, rx_data_o, wr_op_o;
    logic [8:0] tx_len_i = 0, rx_len_i = 0;
    logic       ready_o, tx_take_o, rx_valid_o, wen_o, pd_o, held_o, wr_start_o, wr_b;
    logic [7:0] rq[$], wq[$];
    int         err_total = 0, n_tests = 0, cyc = 0, b_starts = 0;
    sfi_link_if link();
    sfi_link_if link_b();

    sfi_host #(.PU_CYC(PU), .HALF(8)) u_sfi_host (.clk_i(clk_i), .reset_i(reset_i), .link(link),
        .start_i(start_i), .op_i(op_i), .tx_len_i(tx_len_i), .rx_len_i(rx_len_i), .tx_data_i(tx_data_i),
        .hold_req_i(hold_req_i), .ready_o(ready_o), .tx_take_o(tx_take_o), .rx_data_o(rx_data_o),
        .rx_valid_o(rx_valid_o));
    sfi_device #(.MAKER_ID(IDS[0]), .TYPE_ID(IDS[1]), .CAP_ID(IDS[2]), .SHORT_ID(IDS[4])) u_sfi_device (
        .clk_i(clk_i), .reset_i(reset_i), .link(link), .busy_i(busy_i), .write_done_i(write_done_i),
        .wen_o(wen_o), .pd_o(pd_o), .held_o(held_o), .wr_start_o(wr_start_o), .wr_op_o(wr_op_o));
    // Second device faces a bit-level driver that can cut a byte short
    sfi_device u_sfi_device_b (.clk_i(clk_i), .reset_i(reset_i), .link(link_b), .busy_i(1'b0),
        .write_done_i(1'b0), .wen_o(), .pd_o(), .held_o(), .wr_start_o(wr_b), .wr_op_o());
    sfi_link_sva #(.PU_CYC(PU)) u_sfi_link_sva (.clk_i(clk_i), .reset_i(reset_i), .cs_n(link.cs_n),
        .sck(link.sck), .so(link.so), .so_oe(link.so_oe), .hold_n(link.hold_n));

    // --------------------------
    // Clock, data source, watchers
    // --------------------------
    always #2.5 clk_i = ~clk_i;

    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr

    // Next tx byte only after the host took the last one
    always @(negedge clk_i) begin
        if (tx_take_o) begin
            rnd = lfsr(rnd);
            tx_data_i <= rnd;
        end
    end

    // Results are matched against the oldest note
    always @(posedge clk_i) begin
        cyc++;
        if (link.so_oe) oe_seen <= 1'b1;
        if (wr_b === 1'b1) b_starts++;
        if (rx_valid_o === 1'b1 && !ign) begin
            if (rq.size() > 0) chk8(rx_data_o, rq.pop_front());
            else chk1(1'b1, 1'b0);
        end
        if (wr_start_o === 1'b1) begin
            if (wq.size() > 0) chk8(wr_op_o, wq.pop_front());
            else chk1(1'b1, 1'b0);
        end
        if (cyc == 40000) begin
            err_total++;
            complete_run();
        end
    end

    // --------------------------
    // Tasks
    // --------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk1

    // Waits are bounded so a stuck host ends in the report
    task automatic frame(input logic [7:0] op, input int tx, input int rx);
        int n;
        n = 0;
        @(negedge clk_i);
        while (ready_o !== 1'b1 && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        op_i = op;
        tx_len_i = 9'(tx);
        rx_len_i = 9'(rx);
        start_i = 1;
        @(negedge clk_i);
        start_i = 0;
        repeat (2) @(negedge clk_i);
        while (ready_o !== 1'b1 && n < 4000) begin
            @(negedge clk_i);
            n++;
        end
        if (ready_o !== 1'b1) err_total++; // Stuck frame counts as a mismatch
        repeat (4) @(negedge clk_i);
    endtask : frame

    task automatic pulse_done();
        write_done_i = 1;
        @(negedge clk_i);
        write_done_i = 0;
        @(negedge clk_i);
    endtask : pulse_done

    // Raw frame of nb bits, 80 ns clock, MSB first; hold with stray clocks before bit hb
    task automatic bang(input logic [39:0] v, input int nb, input int hb);
        link_b.cs_n = 0;
        for (int i = 0; i < nb; i++) begin
            if (i == hb) begin
                repeat (4) @(negedge clk_i);
                link_b.hold_n = 0;
                link_b.si = ~v[39-i];
                repeat (3) begin
                    repeat (8) @(negedge clk_i);
                    link_b.sck = 1;
                    repeat (8) @(negedge clk_i);
                    link_b.sck = 0;
                end
                repeat (8) @(negedge clk_i);
                link_b.hold_n = 1;
            end
            link_b.si = v[39-i];
            repeat (8) @(negedge clk_i);
            link_b.sck = 1;
            repeat (8) @(negedge clk_i);
            link_b.sck = 0;
        end
        repeat (8) @(negedge clk_i);
        link_b.cs_n = 1;
        repeat (16) @(negedge clk_i);
    endtask : bang

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    // --------------------------
    // Main sequence
    // --------------------------
    initial begin
        link_b.cs_n = 1;
        link_b.sck = 0;
        link_b.si = 0;
        link_b.hold_n = 1;
        repeat (16) @(negedge clk_i);
        reset_i = 0;
        chk1(pd_o, 1'b0);
        for (int i = 0; i < 9; i++) rq.push_back(IDS[i%4]);
        frame(`SFI_OP_JEDEC_ID, 0, 9);
        repeat (3) rq.push_back(IDS[4]);
        frame(`SFI_OP_SHORT_ID, 3, 3);
        for (int i = 0; i < 4; i++) rq.push_back(IDS[i]);
        fork
            frame(`SFI_OP_JEDEC_ID, 0, 4);
            begin
                repeat (300) @(negedge clk_i);
                hold_req_i = 1;
                repeat (60) @(negedge clk_i);
                chk1(held_o, 1'b1);
                hold_req_i = 0;
            end
        join
        // Busy: no ID output from either ID read; write enable is also sent
        busy_i = 1;
        ign = 1;
        oe_seen = 0;
        frame(`SFI_OP_JEDEC_ID, 0, 2);
        frame(`SFI_OP_SHORT_ID, 3, 1);
        frame(`SFI_OP_WR_EN, 0, 0);
        chk1(oe_seen, 1'b0);
        busy_i = 0;
        ign = 0;
        for (int i = 0; i < 7; i++) begin
            frame(`SFI_OP_WR_EN, 0, 0);
            wq.push_back(WOPS[i]);
            frame(WOPS[i], WLEN[i], 0);
            pulse_done();
            chk1(wen_o, 1'b0);
        end
        frame(`SFI_OP_WR_EN, 0, 0);
        frame(`SFI_OP_STAT_WR, 2, 0);
        chk1(wen_o, 1'b1);
        frame(`SFI_OP_PWR_DOWN, 0, 0);
        chk1(pd_o, 1'b1);
        rq.push_back(IDS[4]);
        frame(`SFI_OP_SHORT_ID, 3, 1);
        chk1(pd_o, 1'b0);
        bang({`SFI_OP_WR_EN, 32'h0}, 8, 99);
        bang({`SFI_OP_SS_ERASE, rnd, 24'h0}, 31, 99);
        chk8(8'(b_starts), 8'h00);
        bang({`SFI_OP_SS_ERASE, rnd, 24'h0}, 32, 99);
        chk8(8'(b_starts), 8'h01);
        // Stray clocks while held must not count, so the frame stays whole
        bang({`SFI_OP_SS_ERASE, rnd, 24'h0}, 32, 12);
        chk8(8'(b_starts), 8'h02);
        repeat (20) @(negedge clk_i);
        chk8(8'(rq.size() + wq.size()), 8'h00);
        complete_run();
    end
endmodule : test_serial_flash_id_hold_protect
